/* rwct_pkg.sv */
// Package: register map, word layout and encodings of the word checker
package rwct_pkg;
    // ======================================================================
    // Register map (byte offsets)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] FIFOCLR_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    // ======================================================================
    // Field positions
    localparam int STS_PARITY_ERROR_FLAG_BIT = 0;
    localparam int STS_MODE_LSB = 1;
    localparam int STS_SEQUENCE_ERROR_FLAG_BIT = 8;
    localparam int PAR_BIT = 47;
    localparam int KIND_A_BIT = 46;
    localparam int KIND_B_BIT = 45;
    localparam int STAMP_LSB = 48;
    // ======================================================================
    // Reset values and counts
    localparam logic [1:0] MODE_RST = 2'h1;
    localparam logic [2:0] LANE_BEATS = 3'h6;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    // Status encoding of the active mode
    localparam logic [1:0] STS_MODE_FREQ = 2'h2;
    localparam logic [1:0] STS_MODE_GRAD = 2'h0;
    localparam logic [1:0] STS_MODE_DIG = 2'h1;
    // ======================================================================
    // Decoded operating modes
    typedef enum logic [1:0]
    {
        MODE_FREQ = 2'b01,
        MODE_GRAD = 2'b00,
        MODE_DIG = 2'b10
    } rwct_mode_t;
endpackage : rwct_pkg

/* rwct_rx_word_checker.sv */
// Receive word checker, sequencer and interval time stamper
`timescale 1ns/10ps
module rwct_rx_word_checker
    import rwct_pkg::*;
#(
    parameter int LANES = 8,
    parameter int WORD_W = 48,
    parameter bit PARITY_ODD = 1'b0
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    // Link pins, asynchronous to clk
    input wire logic linkClk,
    input wire logic [LANES-1:0] linkData,
    // FIFO write side
    output logic fifoWrEn,
    output logic [63:0] fifoWrData,
    output logic fifoClear
);
    // ======================================================================
    // Helpers
    // Parity of a received word, polarity chosen by parameter
    function automatic logic parityBad(input logic [WORD_W-1:0] w);
        parityBad = (^w) ^ PARITY_ODD;
    endfunction : parityBad

    // Register address compare
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    // ======================================================================
    // Pin synchronisers
    logic [LANES:0] syncA_q; // First stage, only read by second
    logic [LANES:0] syncB_q; // Second stage, safe to use
    logic linkClkOld_q; // Previous link clock level for edge find

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge clk)
    begin
        syncA_q <= {linkClk, linkData};
        syncB_q <= syncA_q;
        linkClkOld_q <= syncB_q[LANES];
    end

    // Rising link edge; needs clk at least twice the link rate
    wire linkRise = syncB_q[LANES] & ~linkClkOld_q;

    // ======================================================================
    // Deserialiser: six beats of eight lanes make one word
    logic [WORD_W-1:0] shift_q; // Word being assembled
    logic [2:0] beat_q; // Beats collected so far
    logic [WORD_W-1:0] word_q; // Complete word
    logic wordStb_q; // One pulse per complete word
    wire lastBeat = (beat_q == LANE_BEATS - 3'h1);
    wire [WORD_W-1:0] shiftNext = {shift_q[WORD_W-LANES-1:0],
        syncB_q[LANES-1:0]};

    // Word boundary counted from reset; the sender starts aligned
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            shift_q <= '0;
            beat_q <= 3'h0;
            word_q <= '0;
            wordStb_q <= 1'b0;
        end
        else
        begin
            wordStb_q <= linkRise & lastBeat;
            if (linkRise)
            begin
                shift_q <= shiftNext;
                beat_q <= lastBeat ? 3'h0 : beat_q + 3'h1;
                // Latch whole word at last beat
                if (lastBeat)
                    word_q <= shiftNext;
            end
        end
    end

    // ======================================================================
    // Register decode
    logic [1:0] mode_q; // Mode field, software written
    wire ctrlWr = regWr & hit(regAddr, CTRL_OFS);
    wire clrWr = regWr & hit(regAddr, FIFOCLR_OFS);
    wire modeFreq = mode_q[0];
    wire modeGrad = (mode_q == MODE_GRAD);
    wire modeDig = (mode_q == MODE_DIG);
    wire [1:0] stsMode = modeFreq ? STS_MODE_FREQ :
        (modeGrad ? STS_MODE_GRAD : STS_MODE_DIG);

    // Mode register; takes effect on the next word
    always_ff @(posedge clk)
    begin
        if (srst)
            mode_q <= MODE_RST;
        else if (ctrlWr)
            mode_q <= regWrData[1:0];
    end

    // ======================================================================
    // Word classification
    wire kA = word_q[KIND_A_BIT]; // Kind bit, or not-valid, not-data
    wire kB = word_q[KIND_B_BIT]; // Not-marker, or not-control
    wire [1:0] pair = {kA, kB};
    logic prevPrim_q; // Last word in frequency mode was primary
    logic firstData_q; // Next gradient data word is the first
    logic [31:0] cnt_q; // Interval counter

    // Frequency mode outcome
    wire fAcc = ~kA | prevPrim_q;
    wire fKey = ~kA;
    wire fErr = ~kA & prevPrim_q;
    // Gradient mode outcome
    wire gAcc = (pair != 2'b11);
    wire gKey = ~kB;
    wire gErr = (pair == 2'b00);
    wire gHigh = (pair == 2'b01) & firstData_q;
    // Digitizer mode outcome
    wire dAcc = (pair != 2'b11);
    wire dKey = ~kB;
    wire dErr = (pair == 2'b00);

    // Key words follow the mode
    wire accept = modeFreq ? fAcc : (modeGrad ? gAcc : dAcc);
    wire isKey = modeFreq ? fKey : (modeGrad ? gKey : dKey);
    wire seqBad = modeFreq ? fErr : (modeGrad ? gErr : dErr);
    wire useHigh = modeFreq ? kA : (modeGrad & gHigh);

    // High half kept from the last key word, before the counter cleared
    logic [15:0] hiHold_q;

    // Stamp selection; digitizer words only ever see the low half
    wire [15:0] stamp = useHigh ? hiHold_q :
        ((isKey | modeDig) ? cnt_q[15:0] : 16'h0000);

    // ======================================================================
    // Sequence state
    always_ff @(posedge clk)
    begin
        if (srst | clrWr)
        begin
            prevPrim_q <= 1'b0;
            firstData_q <= 1'b0;
        end
        else if (wordStb_q)
        begin
            // Secondary valid only in the period right after primary
            prevPrim_q <= modeFreq & ~kA;
            // Marker (or undefined 00) arms first-data stamping
            if (modeGrad & ~kB)
                firstData_q <= 1'b1;
            else if (modeGrad & (pair == 2'b01))
                firstData_q <= 1'b0;
        end
    end

    // ======================================================================
    // Interval counter: one count per received word period
    always_ff @(posedge clk)
    begin
        if (srst | clrWr)
            cnt_q <= CNT_RST;
        else if (wordStb_q)
        begin
            // Key word restarts at zero
            if (accept & isKey)
                cnt_q <= CNT_RST;
            else
                cnt_q <= cnt_q + 32'h1;
        end
    end

    // ======================================================================
    // High-half hold: the key word clears the counter, so its upper
    // half would be lost before the following data word arrives
    always_ff @(posedge clk)
    begin
        if (srst | clrWr)
        begin
            // Nothing measured yet
            hiHold_q <= 16'h0000;
        end
        else if (wordStb_q & accept & isKey)
        begin
            // Capture at the key word, used by the next secondary or gradient data word
            hiHold_q <= cnt_q[31:16];
        end
    end

    // ======================================================================
    // Error flags; a new error wins over a clear in the same cycle
    logic seqErr_q; // Sequence error flag
    logic parErr_q; // Parity error flag
    wire seqSet = wordStb_q & seqBad;
    wire parSet = wordStb_q & parityBad(word_q);

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            seqErr_q <= 1'b0;
            parErr_q <= 1'b0;
        end
        else
        begin
            seqErr_q <= seqSet | (seqErr_q & ~clrWr);
            parErr_q <= parSet | (parErr_q & ~clrWr);
        end
    end

    // ======================================================================
    // FIFO write: faulty words stored too, idles never
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            fifoWrEn <= 1'b0;
            fifoWrData <= '0;
            fifoClear <= 1'b0;
        end
        else
        begin
            fifoClear <= clrWr;
            fifoWrEn <= wordStb_q & accept & ~clrWr;
            if (wordStb_q & accept)
                fifoWrData <= {stamp, word_q};
        end
    end

    // ======================================================================
    // Read data; unmapped addresses return status
    wire [15:0] stsWord = {7'h00, seqErr_q, 5'h00, stsMode, parErr_q};
    wire [15:0] rdMux = hit(regAddr, CTRL_OFS) ? {14'h0000, mode_q} :
        stsWord;

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clk)
    begin
        if (srst)
            regRdData <= 16'h0000;
        else
            regRdData <= regRd ? rdMux : 16'h0000;
    end

    // ======================================================================
    // Assertions
    sequence sWordIn;
        wordStb_q && accept;
    endsequence

    sequence sWrite;
        fifoWrEn;
    endsequence

    a_word_stored: assert property (@(posedge clk) disable iff (srst)
        sWordIn and !clrWr |=> sWrite)
        else $error("accepted word not written");

    a_idle_dropped: assert property (@(posedge clk) disable iff (srst)
        wordStb_q && !modeFreq && pair == 2'b11 |=> !fifoWrEn)
        else $error("idle word written");

    a_key_clears: assert property (@(posedge clk) disable iff (srst)
        sWordIn and isKey && !clrWr |=> cnt_q == 32'h0)
        else $error("key word did not clear counter");

    a_count_step: assert property (@(posedge clk) disable iff (srst)
        wordStb_q && !(accept && isKey) && !clrWr
        |=> cnt_q == $past(cnt_q) + 32'h1)
        else $error("counter did not advance");

    a_key_stamp: assert property (@(posedge clk) disable iff (srst)
        sWordIn and isKey && !clrWr
        |=> fifoWrData[63:48] == $past(cnt_q[15:0]))
        else $error("key stamp wrong");

    a_freq_high: assert property (@(posedge clk) disable iff (srst)
        sWordIn and modeFreq && kA && !clrWr
        |=> fifoWrData[63:48] == $past(hiHold_q))
        else $error("secondary stamp wrong");

    a_hold_key: assert property (@(posedge clk) disable iff (srst)
        sWordIn and isKey && !clrWr
        |=> hiHold_q == $past(cnt_q[31:16]))
        else $error("high half not held at key word");

    a_grad_high: assert property (@(posedge clk) disable iff (srst)
        sWordIn and modeGrad && pair == 2'b01 && firstData_q && !clrWr
        |=> fifoWrData[63:48] == $past(hiHold_q))
        else $error("first gradient data stamp wrong");

    a_freq_dup: assert property (@(posedge clk) disable iff (srst)
        wordStb_q && modeFreq && kA && !prevPrim_q |=> !fifoWrEn)
        else $error("secondary after secondary stored");

    a_seq_sticky: assert property (@(posedge clk) disable iff (srst)
        seqSet |=> seqErr_q ##1 (seqErr_q || $past(clrWr)))
        else $error("sequence flag lost");

    a_par_set: assert property (@(posedge clk) disable iff (srst)
        parSet |=> parErr_q)
        else $error("parity flag not set");

    a_clear_flags: assert property (@(posedge clk) disable iff (srst)
        clrWr && !seqSet && !parSet |=> !seqErr_q && !parErr_q)
        else $error("flags not cleared");

    a_grad_err: assert property (@(posedge clk) disable iff (srst)
        wordStb_q && modeGrad && pair == 2'b00 |=> seqErr_q)
        else $error("gradient 00 not flagged");

    a_dig_data: assert property (@(posedge clk) disable iff (srst)
        sWordIn and modeDig && pair == 2'b01 && !clrWr
        |=> cnt_q == $past(cnt_q) + 32'h1 ##0
        fifoWrData[63:48] == $past(cnt_q[15:0]))
        else $error("digitizer data stamp wrong");

    a_grad_marker: assert property (@(posedge clk) disable iff (srst)
        sWordIn and modeGrad && pair == 2'b10 && !clrWr
        |=> firstData_q)
        else $error("marker did not arm first data");

    a_freq_err: assert property (@(posedge clk) disable iff (srst)
        wordStb_q && modeFreq && !kA && prevPrim_q |=> seqErr_q)
        else $error("primary repeat not flagged");

    a_digit_low: assert property (@(posedge clk) disable iff (srst)
        sWordIn and modeDig && !clrWr
        |=> fifoWrData[63:48] == $past(cnt_q[15:0]))
        else $error("digitizer stamp not low half");

    a_mode_write: assert property (@(posedge clk) disable iff (srst)
        ctrlWr |=> mode_q == $past(regWrData[1:0]))
        else $error("mode not taken");

    a_word_rate: assert property (@(posedge clk) disable iff (srst)
        wordStb_q |=> !wordStb_q)
        else $error("word strobe longer than one cycle");
endmodule : rwct_rx_word_checker

/* rwct_link_model.sv */
// Link sender model: six 8-lane beats per 48-bit word
`timescale 1ns/10ps
// ======================================================================
// Sender
module rwct_link_model
(
    // Link pins
    output logic linkClk,
    output logic [7:0] linkData
);
    // Clock parked low outside frames, lanes start low
    initial
    begin
        linkClk = 1'b0;
        linkData = 8'h00;
    end
    // One word, top lane group first, 320 ns per beat
    task automatic send(input logic [47:0] w);
        for (int i = 5; i >= 0; i--)
        begin
            linkData = w[i*8 +: 8];
            #80;
            linkClk = 1'b1;
            #160;
            linkClk = 1'b0;
            #80;
        end
        // Released lanes must not keep showing the last beat
        linkData = ~linkData;
    endtask : send
endmodule : rwct_link_model

/* test_rwct_rx_word_checker.sv */
// Self-checking bench for the receive word checker
`timescale 1ns/10ps
module test_rwct_rx_word_checker
    import rwct_pkg::*;
;
    // ==================================================================
    // Design signals
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdData;
    logic linkClk;
    logic [7:0] linkData;
    logic fifoWrEn;
    logic [63:0] fifoWrData;
    logic fifoClear;
    // Scoreboard: expected FIFO entries and read data, oldest first
    logic [63:0] fq[$];
    logic [15:0] rq[$];
    logic rdPend = 1'b0;
    int n_fail = 0;
    int n_tests = 0;
    int clrSeen = 0;
    int clrWant = 0;
    // Reference state: counter counts words, not clock cycles
    rwct_mode_t mode = MODE_FREQ;
    logic [31:0] cnt = 32'h0;
    logic [15:0] hiQ = 16'h0;
    logic prevA = 1'b0;
    logic arm = 1'b0;
    logic seqE = 1'b0;
    logic parE = 1'b0;
    logic [31:0] lfsr = 32'h6A5E;
    // 25 MHz clock
    always #20 clk = ~clk;
    rwct_rx_word_checker u_dut (.clk(clk), .srst(srst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .linkClk(linkClk), .linkData(linkData),
        .fifoWrEn(fifoWrEn), .fifoWrData(fifoWrData), .fifoClear(fifoClear));
    rwct_link_model u_link (.linkClk(linkClk), .linkData(linkData));
    // ==================================================================
    // Helpers
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        nextRand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nextRand
    function automatic logic [15:0] stsExp();
        logic [1:0] c;
        c = (mode == MODE_FREQ) ? STS_MODE_FREQ :
            (mode == MODE_GRAD) ? STS_MODE_GRAD : STS_MODE_DIG;
        stsExp = {7'h00, seqE, 5'h00, c, parE};
    endfunction : stsExp
    task automatic close_out();
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Bus master: one-cycle strobes launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        rq.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
    endtask : rd
    task automatic modelClear();
        cnt = 32'h0;
        prevA = 1'b0;
        arm = 1'b0;
        seqE = 1'b0;
        parE = 1'b0;
    endtask : modelClear
    task automatic clear();
        wr(FIFOCLR_OFS, 16'h0000);
        clrWant++;
        modelClear();
    endtask : clear
    // Build one word with kind pair p, predict the entry, send it
    task automatic sendw(input logic [1:0] p, input logic good);
        logic [47:0] w;
        logic acc;
        logic clr;
        logic [15:0] st;
        lfsr = nextRand(lfsr);
        w = {1'b0, p, lfsr[12:0], lfsr};
        w[47] = ^w[46:0] ^ ~good;
        acc = 1'b1;
        clr = 1'b0;
        st = 16'h0;
        if (mode == MODE_FREQ)
        begin
            // Primary clears, secondary only right after a primary
            if (!p[1])
            begin
                st = cnt[15:0];
                clr = 1'b1;
                seqE |= prevA;
                prevA = 1'b1;
            end
            else
            begin
                acc = prevA;
                st = hiQ;
                prevA = 1'b0;
            end
        end
        else if (p == 2'h3)
            acc = 1'b0;
        else if (mode == MODE_GRAD && p == 2'h1)
        begin
            // Only the first valid word after a marker or a 00 word is stamped
            st = arm ? hiQ : 16'h0;
            arm = 1'b0;
        end
        else
        begin
            st = cnt[15:0];
            clr = (p != 2'h1);
            seqE |= (p == 2'h0);
            arm = 1'b1;
        end
        parE |= !good;
        if (clr)
            hiQ = cnt[31:16];
        cnt = clr ? 32'h0 : cnt + 32'h1;
        if (acc)
            fq.push_back({st, w});
        u_link.send(w);
    endtask : sendw
    // Codes are 3 bits each, first word lowest: {bad parity, pair}
    task automatic play(input int n, input logic [23:0] codes);
        int i;
        for (i = 0; i < n; i++)
            sendw(codes[3*i +: 2], !codes[3*i+2]);
        for (i = 0; i < 40 && fq.size() > 0; i++)
            @(posedge clk);
        if (fq.size() > 0)
        begin
            check(64'h1, 64'h0);
            close_out();
        end
        repeat (4) @(posedge clk);
    endtask : play
    // ==================================================================
    // Monitor: pops the oldest note whenever a result appears
    always @(posedge clk)
    begin
        rdPend <= regRd;
        if (fifoClear === 1'b1)
            clrSeen <= clrSeen + 1;
        if (fifoWrEn === 1'b1 && fq.size() == 0)
            check(64'h1, 64'h0);
        else if (fifoWrEn === 1'b1)
            check(fifoWrData, fq.pop_front());
        if (rdPend)
            check({48'h0, regRdData}, {48'h0, rq.pop_front()});
    end
    // ==================================================================
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rd(STATUS_OFS, stsExp());
        rd(CTRL_OFS, 16'h0001);
        // Frequency: A B B A A, then a B with bad parity
        play(6, {3'h6, 3'h0, 3'h0, 3'h2, 3'h2, 3'h0});
        rd(STATUS_OFS, stsExp());
        rd(8'h20, stsExp());
        clear();
        rd(STATUS_OFS, stsExp());
        // Gradient: marker, valid, valid, bad idle, 00, marker, valid
        wr(CTRL_OFS, {14'h0, MODE_GRAD});
        mode = MODE_GRAD;
        clear();
        play(7, {3'h1, 3'h2, 3'h0, 3'h7, 3'h1, 3'h1, 3'h2});
        rd(STATUS_OFS, stsExp());
        // Digitizer: control, data, idle, data, 00, control
        wr(CTRL_OFS, {14'h0, MODE_DIG});
        mode = MODE_DIG;
        clear();
        play(6, {3'h2, 3'h0, 3'h1, 3'h3, 3'h1, 3'h2});
        rd(STATUS_OFS, stsExp());
        rd(CTRL_OFS, 16'h0002);
        // Mid-run reset drops flags and returns to frequency mode
        @(posedge clk);
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        mode = MODE_FREQ;
        modelClear();
        rd(STATUS_OFS, stsExp());
        play(2, {3'h2, 3'h0});
        check(clrSeen, clrWant);
        close_out();
    end
endmodule : test_rwct_rx_word_checker
